// *** rtl/rx_lock_and_clock_select.sv ***
// What this block does
// - Receive clock at bit/20 or bit/10
// - Retimer clock equals or doubles receive clock
// - Retimer clock from character clock, no phase
// - Reset puts all state to defaults
// - Reset never touches boundary-scan controller
// - Gate high: level, range, density all decide
// - Any deciding detector out: lock to reference
// - No transition in 60 bits is fault
// - Gate low: range detector alone decides
// - Force low: lock to reference clock
// - Force low holds fault flag low
// - Force high: recover from serial stream
// - Receive clock may drift without transitions
// - Fault flag active low, OR of seven with gate high
// - Reference clock drives range detector
module rx_lock_and_clock_select #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial side, one bit per clock per channel
  input wire logic [CHANNELS-1:0] serial_bit_i,
  input wire logic [CHANNELS-1:0] level_ok_i,
  input wire logic [CHANNELS-1:0] range_ok_i,
  input wire logic [CHANNELS*4-1:0] other_fault_i,
  input wire logic [CHANNELS*2-1:0] level_trip_select_i,
  // Clock and status outputs
  output logic [CHANNELS-1:0] recovered_word_clock_o,
  output logic [CHANNELS-1:0] retimer_clock_out_o,
  output logic [CHANNELS-1:0] link_fault_flag_n_o,
  output logic [CHANNELS-1:0] track_data_o,
  output logic [CHANNELS*2-1:0] level_trip_o,
  output logic irq_o,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [rx_lock_pkg::ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  // Control register: rate and force per channel, one shared gate
  logic [CHANNELS-1:0] rate_r, rate_nxt;
  logic gate_r, gate_nxt;
  logic [CHANNELS-1:0] force_r, force_nxt;
  logic [CHANNELS*rx_lock_pkg::EV_W-1:0] ev_stat_r, ev_stat_nxt;
  logic [CHANNELS*rx_lock_pkg::EV_W-1:0] ev_mask_r, ev_mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [CHANNELS*rx_lock_pkg::EV_W-1:0] ev_pulse;
  logic wr_ok;

  // Boundary-scan controller sits outside; rst_i is not routed there
  assign level_trip_o = level_trip_select_i;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      rx_lock_channel u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .serial_bit_i(serial_bit_i[g]),
        .level_ok_i(level_ok_i[g]),
        .range_ok_i(range_ok_i[g]),
        .other_fault_i(other_fault_i[g*4 +: 4]),
        .gate_i(gate_r),
        .force_n_i(force_r[g]),
        .rate_i(rate_r[g]),
        .word_clk_o(recovered_word_clock_o[g]),
        .retimer_clk_o(retimer_clock_out_o[g]),
        .fault_n_o(link_fault_flag_n_o[g]),
        .track_data_o(track_data_o[g]),
        .ev_o(ev_pulse[g*rx_lock_pkg::EV_W +: rx_lock_pkg::EV_W])
      );
    end
  endgenerate

  // Commit on the edge at which the master sees ack
  assign wr_ok = cyc_i && stb_i && we_i && ack_r && sel_i[0];
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign irq_o = |(ev_stat_r & ev_mask_r);

  always_comb begin
    rate_nxt = rate_r;
    gate_nxt = gate_r;
    force_nxt = force_r;
    ev_mask_nxt = ev_mask_r;
    ev_stat_nxt = ev_stat_r;
    ack_nxt = cyc_i && stb_i && !ack_r;
    dat_nxt = rx_lock_pkg::ZERO_WORD;
    if (wr_ok && adr_i == rx_lock_pkg::CTRL_OFS) begin
      gate_nxt = dat_i[2*CHANNELS];
      for (int i = 0; i < CHANNELS; i++) begin
        rate_nxt[i] = dat_i[i];
        force_nxt[i] = dat_i[CHANNELS + i];
      end
    end
    if (wr_ok && adr_i == rx_lock_pkg::IRQ_MASK_OFS) begin
      ev_mask_nxt = dat_i[CHANNELS*rx_lock_pkg::EV_W-1:0];
    end
    // Write-one-to-clear; a new event in the same cycle wins
    if (wr_ok && adr_i == rx_lock_pkg::IRQ_STAT_OFS) begin
      ev_stat_nxt = ev_stat_nxt & ~dat_i[CHANNELS*rx_lock_pkg::EV_W-1:0];
    end
    ev_stat_nxt = ev_stat_nxt | ev_pulse;
    if (cyc_i && stb_i && !we_i && !ack_r) begin
      case (adr_i)
        rx_lock_pkg::CTRL_OFS: begin
          dat_nxt[CHANNELS-1:0] = rate_r;
          dat_nxt[2*CHANNELS-1:CHANNELS] = force_r;
          dat_nxt[2*CHANNELS] = gate_r;
        end
        rx_lock_pkg::STATUS_OFS: begin
          dat_nxt[CHANNELS-1:0] = track_data_o;
          dat_nxt[2*CHANNELS-1:CHANNELS] = link_fault_flag_n_o;
        end
        rx_lock_pkg::IRQ_STAT_OFS: dat_nxt[CHANNELS*rx_lock_pkg::EV_W-1:0] = ev_stat_r;
        rx_lock_pkg::IRQ_MASK_OFS: dat_nxt[CHANNELS*rx_lock_pkg::EV_W-1:0] = ev_mask_r;
        default: dat_nxt = rx_lock_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_r <= '0;
      gate_r <= 1'b1;
      force_r <= '1;
      ev_stat_r <= '0;
      ev_mask_r <= '0;
      ack_r <= 1'b0;
      dat_r <= rx_lock_pkg::ZERO_WORD;
    end else begin
      rate_r <= rate_nxt;
      gate_r <= gate_nxt;
      force_r <= force_nxt;
      ev_stat_r <= ev_stat_nxt;
      ev_mask_r <= ev_mask_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end
endmodule // rx_lock_and_clock_select

// One receive channel: lock decision and clock generation
module rx_lock_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Detectors
  input wire logic serial_bit_i,
  input wire logic level_ok_i,
  input wire logic range_ok_i,
  input wire logic [3:0] other_fault_i,
  // Control
  input wire logic gate_i,
  input wire logic force_n_i,
  input wire logic rate_i,
  // Outputs
  output logic word_clk_o,
  output logic retimer_clk_o,
  output logic fault_n_o,
  output logic track_data_o,
  output logic [rx_lock_pkg::EV_W-1:0] ev_o
);
  logic td_ok, det_ok;
  logic [rx_lock_pkg::DIV_W-1:0] half_w, rt_high, rt_low;

  // Range check uses the training reference as its frequency source
  assign det_ok = gate_i ? (level_ok_i && range_ok_i && td_ok)
                         : range_ok_i;
  assign half_w = rate_i ? rx_lock_pkg::CHAR_DIV : rx_lock_pkg::HALF_CHAR_DIV;
  // At character rate 2 + 3 cycles give exactly twice the word clock
  assign rt_high = rate_i ? (rx_lock_pkg::CHAR_DIV >> 1) : half_w;
  assign rt_low = rate_i ? (rx_lock_pkg::CHAR_DIV - rt_high) : half_w;

  // Run length counted in the serial domain model, one bit per clock
  rx_density_detector u_td (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .serial_bit_i(serial_bit_i),
    .ok_o(td_ok)
  );

  rx_lock_decider u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .force_n_i(force_n_i),
    .det_ok_i(det_ok),
    .other_fault_i(other_fault_i),
    .fault_n_o(fault_n_o),
    .track_data_o(track_data_o),
    .ev_o(ev_o)
  );

  // Free-running divider: clock never stops, only its source moves
  rx_clock_divider #(.CNT_W(rx_lock_pkg::DIV_W)) u_word_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .high_len_i(half_w),
    .low_len_i(half_w),
    .clk_o(word_clk_o)
  );

  // Own counter from the character clock, no phase tie to word clock
  rx_clock_divider #(.CNT_W(rx_lock_pkg::DIV_W)) u_rt_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .high_len_i(rt_high),
    .low_len_i(rt_low),
    .clk_o(retimer_clk_o)
  );
endmodule // rx_lock_channel

// Lock source and fault flag for one channel
module rx_lock_decider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Decision inputs
  input wire logic force_n_i,
  input wire logic det_ok_i,
  input wire logic [3:0] other_fault_i,
  // Decision outputs
  output logic fault_n_o,
  output logic track_data_o,
  output logic [rx_lock_pkg::EV_W-1:0] ev_o
);
  rx_lock_pkg::lock_src_t src_r, src_nxt;
  logic fault_n_r, fault_n_nxt;

  always_comb begin
    case (src_r)
      rx_lock_pkg::SRC_REF: begin
        if (force_n_i && det_ok_i) src_nxt = rx_lock_pkg::SRC_DATA;
        else src_nxt = rx_lock_pkg::SRC_REF;
      end
      rx_lock_pkg::SRC_DATA: begin
        if (!force_n_i || !det_ok_i) src_nxt = rx_lock_pkg::SRC_REF;
        else src_nxt = rx_lock_pkg::SRC_DATA;
      end
      default: src_nxt = rx_lock_pkg::SRC_REF;
    endcase
    fault_n_nxt = force_n_i && det_ok_i && !(|other_fault_i);
    ev_o[rx_lock_pkg::EV_FAULT_SET] = fault_n_r && !fault_n_nxt;
    ev_o[rx_lock_pkg::EV_LOCK_REF] = (src_r == rx_lock_pkg::SRC_DATA)
                                   && (src_nxt == rx_lock_pkg::SRC_REF);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= rx_lock_pkg::SRC_REF;
      fault_n_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  assign fault_n_o = fault_n_r;
  assign track_data_o = (src_r == rx_lock_pkg::SRC_DATA);
endmodule // rx_lock_decider

// Transition-density check, one serial bit per clock
module rx_density_detector #(
  parameter int CNT_W = rx_lock_pkg::TD_CNT_W,
  parameter int LIMIT_BITS = rx_lock_pkg::TD_LIMIT_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial stream
  input wire logic serial_bit_i,
  // Within limits
  output logic ok_o
);
  localparam logic [CNT_W-1:0] RUN_LIMIT = CNT_W'(LIMIT_BITS);
  localparam logic [CNT_W-1:0] RUN_STEP = CNT_W'(1);
  logic [CNT_W-1:0] run_r, run_nxt;
  logic prev_bit_r, prev_bit_nxt;

  // Saturates at the limit so a long quiet line cannot wrap back to ok
  assign ok_o = run_r < RUN_LIMIT;

  always_comb begin
    prev_bit_nxt = serial_bit_i;
    run_nxt = run_r;
    if (serial_bit_i != prev_bit_r) begin
      run_nxt = '0;
    end else if (ok_o) begin
      run_nxt = run_r + RUN_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= '0;
      prev_bit_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      prev_bit_r <= prev_bit_nxt;
    end
  end
endmodule // rx_density_detector

// Free-running clock divider with separate high and low spans
module rx_clock_divider #(
  parameter int CNT_W = rx_lock_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Spans in clock cycles, two or more each
  input wire logic [CNT_W-1:0] high_len_i,
  input wire logic [CNT_W-1:0] low_len_i,
  // Divided clock
  output logic clk_o
);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic clk_r, clk_nxt;
  logic [CNT_W-1:0] span;
  logic last;

  assign span = clk_r ? high_len_i : low_len_i;
  // A shorter span after a rate change ends the phase at once, never stretches it
  assign last = (cnt_r >= span - CNT_ONE);

  always_comb begin
    cnt_nxt = last ? '0 : cnt_r + CNT_ONE;
    clk_nxt = last ? !clk_r : clk_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign clk_o = clk_r;
endmodule // rx_clock_divider

// *** rtl/rx_lock_pkg.sv ***
package rx_lock_pkg;
  // Serial bits per character and transition-density run limit
  localparam int BITS_PER_CHAR = 10;
  localparam int TD_LIMIT_BITS = 60;
  localparam int TD_CNT_W = 7;
  localparam logic [TD_CNT_W-1:0] TD_LIMIT = 7'h3C;
  localparam logic [TD_CNT_W-1:0] TD_ZERO = 7'h00;
  // Clock divider terms
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] HALF_CHAR_DIV = 5'h0A;
  localparam logic [DIV_W-1:0] CHAR_DIV = 5'h05;
  localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  // Register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'hC;
  // Control bits
  localparam int CTRL_RATE_BIT = 0;
  localparam int CTRL_GATE_BIT = 1;
  localparam int CTRL_FORCE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  // Event bits
  localparam int EV_W = 2;
  localparam int EV_FAULT_SET = 0;
  localparam int EV_LOCK_REF = 1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Lock source
  typedef enum logic [1:0] {
    SRC_REF = 2'b01,
    SRC_DATA = 2'b10
  } lock_src_t;
endpackage

// *** testbench/rx_lock_checker.sv ***
module rx_lock_checker #(
  parameter int CHANNELS = 2
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [CHANNELS-1:0] range_ok_i,
  input wire logic [CHANNELS*4-1:0] other_fault_i,
  input wire logic [CHANNELS*2-1:0] level_trip_select_i,
  input wire logic [CHANNELS-1:0] recovered_word_clock_o,
  input wire logic [CHANNELS-1:0] retimer_clock_out_o,
  input wire logic [CHANNELS-1:0] link_fault_flag_n_o,
  input wire logic [CHANNELS-1:0] track_data_o,
  input wire logic [CHANNELS*2-1:0] level_trip_o,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wc_r;
  logic [4:0] rt_r;
  // Cycles since last edge; a rate change may cut a half period short
  always_ff @(posedge clk_i) begin
    wc_r <= (rst_i || $changed(recovered_word_clock_o[0])) ? 5'h00 : wc_r + 5'h01;
    rt_r <= (rst_i || $changed(retimer_clock_out_o[0])) ? 5'h00 : rt_r + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_WC_RUNS: assert property (wc_r < 5'h0B)
    else $error("word clock stalled");
  AST_RT_RUNS: assert property (rt_r < 5'h0B)
    else $error("retimer clock stalled");
  AST_RANGE_FLAG: assert property (!range_ok_i[0] |=> !link_fault_flag_n_o[0])
    else $error("range fault not flagged");
  AST_RANGE_TRACK: assert property (!range_ok_i[0] [*2] |=> !track_data_o[0])
    else $error("range fault still tracking");
  AST_OTHER: assert property (|other_fault_i[4 +: 4] |=> !link_fault_flag_n_o[1])
    else $error("other fault not flagged");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=>
    link_fault_flag_n_o == '0 && track_data_o == '0 && recovered_word_clock_o == '0)
    else $error("reset state wrong");
  AST_TRIP: assert property (level_trip_o == level_trip_select_i)
    else $error("trip select not passed");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_DUE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  cover property ($fell(track_data_o[0]));
  cover property ($rose(track_data_o[1]));
  cover property (ack_o);
endmodule // rx_lock_checker

bind rx_lock_and_clock_select rx_lock_checker #(.CHANNELS(CHANNELS)) chk_u (.clk_i, .rst_i,
  .range_ok_i, .other_fault_i, .level_trip_select_i, .recovered_word_clock_o,
  .retimer_clock_out_o, .link_fault_flag_n_o, .track_data_o, .level_trip_o, .cyc_i, .stb_i,
  .ack_o);

// *** testbench/serial_src_model.sv ***
module serial_src_model (
  // Clock
  input wire logic clk_i,
  // Test controls
  input wire logic quiet_i,
  input wire logic level_bad_i,
  input wire logic range_bad_i,
  // Toward the receiver
  output logic serial_bit_o,
  output logic level_ok_o,
  output logic range_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_r = 3'h0;
  always @(posedge clk_i) begin
    ph_r <= ph_r + 3'h1;
    // Quiet line sits still, like a floating input
    if (!quiet_i) serial_bit_o <= ph_r[1];
    level_ok_o <= !level_bad_i;
    range_ok_o <= !range_bad_i;
  end
endmodule // serial_src_model

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [3:0] sel_i, adr_i, trip_sel, trip, clks;
  logic [1:0] serial_bit, level_ok, range_ok, quiet, level_bad, range_bad, wc, rt, fault_n, track;
  logic [7:0] other_fault;
  logic [31:0] dat_i, dat_o, rd;
  int bad_count = 0;
  int num_checks = 0;
  assign clks = {rt, wc};
  rx_lock_and_clock_select #(.CHANNELS(2)) dut_u (.clk_i, .rst_i, .serial_bit_i(serial_bit),
    .level_ok_i(level_ok), .range_ok_i(range_ok), .other_fault_i(other_fault),
    .level_trip_select_i(trip_sel), .recovered_word_clock_o(wc), .retimer_clock_out_o(rt),
    .link_fault_flag_n_o(fault_n), .track_data_o(track), .level_trip_o(trip), .irq_o,
    .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o, .ack_o);
  for (genvar g = 0; g < 2; g++) begin : src_g
    serial_src_model src_u (.clk_i, .quiet_i(quiet[g]), .level_bad_i(level_bad[g]),
      .range_bad_i(range_bad[g]), .serial_bit_o(serial_bit[g]), .level_ok_o(level_ok[g]),
      .range_ok_o(range_ok[g]));
  end
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  // Cycles between two rising edges of one clock output
  task automatic per(input int b, input int exp, input string nm);
    int n, r;
    logic p;
    n = 0;
    r = 0;
    p = clks[b];
    while (r < 2 && n < 200) begin
      @(posedge clk_i);
      n++;
      if (clks[b] === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1) n = 0;
      end
      p = clks[b];
    end
    chk(nm, 32'(n), 32'(exp));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hF;
    {quiet, level_bad, range_bad, other_fault} = '0;
    trip_sel = 4'h9;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(rx_lock_pkg::CTRL_OFS, 32'hFF, 32'h1C, "ctrl reset");
    chk("trip", {28'h0, trip}, 32'h9);
    repeat (20) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'hF, 32'hF, "status");
    rdc(4'h2, 32'hFFFF_FFFF, 32'h0, "unmapped");
    $display("test reset done");
    wb(1'b1, rx_lock_pkg::IRQ_MASK_OFS, 32'h0);
    wb(1'b1, rx_lock_pkg::IRQ_STAT_OFS, 32'hF);
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h18);
    repeat (5) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'hF, 32'hA, "forced");
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wb(1'b1, rx_lock_pkg::IRQ_MASK_OFS, 32'hF);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    wb(1'b1, rx_lock_pkg::IRQ_STAT_OFS, 32'hF);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h1C);
    $display("test force done");
    quiet <= 2'b01;
    repeat (40) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'h3, 32'h3, "quiet short");
    repeat (40) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'h3, 32'h2, "quiet long");
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h0C);
    level_bad <= 2'b10;
    repeat (5) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'h3, 32'h3, "gate low");
    range_bad <= 2'b01;
    repeat (5) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'h3, 32'h2, "gate low range");
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h1C);
    {quiet, range_bad} <= '0;
    repeat (10) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'h3, 32'h1, "gate high level");
    level_bad <= 2'b00;
    other_fault <= 8'h10;
    repeat (5) @(posedge clk_i);
    rdc(rx_lock_pkg::STATUS_OFS, 32'hC, 32'h4, "other fault");
    other_fault <= 8'h00;
    $display("test detectors done");
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h1F);
    per(0, 10, "word clock fast");
    per(2, 5, "retimer fast");
    wb(1'b1, rx_lock_pkg::CTRL_OFS, 32'h1C);
    per(0, 20, "word clock slow");
    per(2, 20, "retimer slow");
    $display("test rates done");
    final_report();
  end
endmodule // testbench
